// File: fmsc_ctrl_regs.v
`timescale 1ns/100ps
`include "fmsc_regs.vh"

// ************************************
// Protection counter for one sync loop
// ************************************
module fmsc_prot (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire       clk_en,
  input  wire       clr,
  input  wire       tick,
  input  wire       det,
  input  wire [4:0] errs,
  input  wire [7:0] allow,
  input  wire [7:0] prot,
  output reg        sync_r
);
  reg  [3:0] cnt_r;  // Protection counter
  wire [3:0] lim;    // Allowed bit errors
  wire       match;  // Code in time with errors within allowance
  wire [3:0] cnt_p1; // Counter plus one

  assign lim    = sync_r ? allow[3:0] : allow[7:4];
  assign match  = det && (errs <= {1'b0, lim});
  assign cnt_p1 = cnt_r + 4'h1;

  // Count at internal timing
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r  <= 4'h0;
      sync_r <= 1'b0;
    end else if (clk_en) begin
      if (clr) begin
        cnt_r  <= 4'h0;
        sync_r <= 1'b0;
      end else if (tick) begin
        if (!sync_r) begin
          if (!match)
            cnt_r <= 4'h0;
          else if (cnt_r >= prot[7:4]) begin
            cnt_r  <= 4'h0;
            sync_r <= 1'b1;
          end else
            cnt_r <= cnt_p1;
        end else begin
          if (match)
            cnt_r <= 4'h0;
          else if (cnt_r >= prot[3:0]) begin
            cnt_r  <= 4'h0;
            sync_r <= 1'b0;
          end else
            cnt_r <= cnt_p1;
        end
      end
    end
  end
endmodule

// ************************************
// Register bank and sync control
// ************************************
module fmsc_ctrl_regs (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire       clk_en,
  input  wire       interface_select,
  input  wire       par_cs_n,
  input  wire       par_wr_n,
  input  wire       par_rd_n,
  input  wire [3:0] par_addr,
  input  wire [7:0] par_din,
  output reg  [7:0] par_dout,
  output wire       par_doe,
  input  wire       ser_ce,
  input  wire       ser_clk,
  input  wire       ser_di,
  output wire       ser_do,
  output wire       ser_do_oe,
  input  wire       blk_tick,
  input  wire       blk_det,
  input  wire [4:0] blk_errs,
  input  wire       frm_tick,
  input  wire       frm_det,
  input  wire [4:0] frm_errs,
  input  wire       data_rdy,
  input  wire       data_good,
  input  wire [7:0] corr_data,
  input  wire [7:0] status_in,
  input  wire [7:0] block_no_in,
  output wire       blk_sync,
  output wire       frm_sync,
  output wire       int_req,
  output wire       vertical_pass_halt,
  output wire       correction_stop,
  output wire       sync_reset,
  output wire       group_check_reset,
  output reg  [7:0] control_two,
  output reg  [7:0] group_crc_input,
  output reg        group_crc_stb
);
  // ************************************
  // Pin synchronisers
  // ************************************
  reg  [1:0] sp_s;     // Interface select
  reg  [1:0] cs_s;     // Chip select active
  reg  [1:0] wr_s;     // Write strobe active
  reg  [1:0] rd_s;     // Read strobe active
  reg  [1:0] ce_s;     // Serial enable
  reg  [1:0] sck_s;    // Serial clock
  reg  [1:0] sdi_s;    // Serial data in
  reg        wr_d;     // Delayed write strobe
  reg        sck_d;    // Delayed serial clock
  reg  [3:0] adr_s0;   // Address pins, first flop
  reg  [3:0] adr_s1;   // Address pins, second flop
  reg  [7:0] din_s0;   // Data pins, first flop
  reg  [7:0] din_s1;   // Data pins, second flop

  // Registers written by the host
  reg  [7:0] bic_error_allowance;
  reg  [7:0] block_sync_protection;
  reg  [7:0] frame_sync_protection;
  reg  [7:0] control_one;

  // Serial engine state
  reg  [7:0] sh_r;     // Shift register
  reg  [3:0] bit_r;    // Bits in current byte
  reg        adr_ok_r; // Address byte taken
  reg  [7:0] sadr_r;   // Serial address
  reg  [7:0] tx_r;     // Output shifter
  reg        tx_on_r;  // Sending data
  reg        int_r;    // Registered interrupt

  wire       ser_mode;  // Serial interface chosen
  wire       par_wr;    // Parallel write event
  wire       sck_rise;  // Serial clock rise
  wire       sck_fall;  // Serial clock fall
  wire       ser_wr;    // Serial byte write
  wire [3:0] wr_adr;    // Write address
  wire [7:0] wr_dat;    // Write data
  wire       wr_en;     // Any write except to 00H
  wire [7:0] sh_nxt;    // Shift in next bit
  wire       pass;      // Data may be output
  wire       halt_out;  // Output suppressed
  reg  [7:0] rd_mux;    // Parallel read data
  reg  [7:0] srd_mux;   // Serial read data

  // Two flops on every pin
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sp_s  <= 2'h0;
      cs_s  <= 2'h0;
      wr_s  <= 2'h0;
      rd_s  <= 2'h0;
      ce_s  <= 2'h0;
      sck_s <= 2'h0;
      sdi_s <= 2'h0;
      wr_d  <= 1'b0;
      sck_d <= 1'b0;
      adr_s0 <= 4'h0;
      adr_s1 <= 4'h0;
      din_s0 <= 8'h00;
      din_s1 <= 8'h00;
    end else if (clk_en) begin
      adr_s0 <= par_addr;
      adr_s1 <= adr_s0;
      din_s0 <= par_din;
      din_s1 <= din_s0;
      sp_s  <= {sp_s[0], interface_select};
      cs_s  <= {cs_s[0], ~par_cs_n};
      wr_s  <= {wr_s[0], ~par_wr_n};
      rd_s  <= {rd_s[0], ~par_rd_n};
      ce_s  <= {ce_s[0], ser_ce};
      sck_s <= {sck_s[0], ser_clk};
      sdi_s <= {sdi_s[0], ser_di};
      wr_d  <= wr_s[1];
      sck_d <= sck_s[1];
    end
  end

  // ************************************
  // Write path
  // ************************************
  // Port chosen by select pin
  assign ser_mode = sp_s[1];
  assign par_wr   = !ser_mode && cs_s[1] && wr_d && !wr_s[1];
  assign sck_rise = ser_mode && ce_s[1] && sck_s[1] && !sck_d;
  assign sck_fall = ser_mode && ce_s[1] && !sck_s[1] && sck_d;
  assign sh_nxt   = {sdi_s[1], sh_r[7:1]};
  assign ser_wr   = sck_rise && adr_ok_r && (bit_r == `FMSC_BITS - 4'h1);
  assign wr_adr   = ser_mode ? sadr_r[3:0] : adr_s1;
  assign wr_dat   = ser_mode ? sh_nxt : din_s1;
  assign wr_en    = (par_wr || ser_wr) && (wr_adr != `FMSC_A_DATA);

  // Register writes
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bic_error_allowance   <= `FMSC_RST_BIC;
      block_sync_protection <= `FMSC_RST_PROT;
      frame_sync_protection <= `FMSC_RST_PROT;
      control_one           <= `FMSC_RST_CTL;
      control_two           <= `FMSC_RST_CTL;
      group_crc_input       <= `FMSC_RST_CTL;
      group_crc_stb         <= 1'b0;
    end else if (clk_en) begin
      group_crc_stb <= 1'b0;
      if (wr_en) begin
        case (wr_adr)
          `FMSC_A_BIC:   bic_error_allowance   <= wr_dat;
          `FMSC_A_BLOCK_SYNC_PROTECTION: block_sync_protection <= wr_dat;
          `FMSC_A_FRAME_SYNC_PROTECTION: frame_sync_protection <= wr_dat;
          `FMSC_A_CONTROL_ONE:  control_one           <= wr_dat;
          `FMSC_A_CONTROL_TWO:  control_two           <= wr_dat;
          `FMSC_A_CRC: begin
            group_crc_input <= wr_dat;
            group_crc_stb   <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // ************************************
  // Control outputs
  // ************************************
  // Vertical correction halt
  assign vertical_pass_halt = control_one[`FMSC_B_VHALT];
  assign correction_stop    = control_one[`FMSC_B_ECSTOP];
  assign sync_reset         = control_one[`FMSC_B_SYNCRST];
  assign group_check_reset  = control_one[`FMSC_B_CRCRST];

  // ************************************
  // Sync protection loops
  // ************************************
  fmsc_prot u_blk (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .clr     (sync_reset),
    .tick    (blk_tick),
    .det     (blk_det),
    .errs    (blk_errs),
    .allow   (bic_error_allowance),
    .prot    (block_sync_protection),
    .sync_r  (blk_sync)
  );

  fmsc_prot u_frm (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .clr     (sync_reset),
    .tick    (frm_tick),
    .det     (frm_det),
    .errs    (frm_errs),
    .allow   (bic_error_allowance),
    .prot    (frame_sync_protection),
    .sync_r  (frm_sync)
  );

  // ************************************
  // Interrupt gating
  // ************************************
  // Good data or all data
  assign pass     = control_one[`FMSC_B_INTALL] || (data_good && blk_sync && frm_sync);
  assign halt_out = sync_reset || correction_stop;
  assign int_req  = int_r;

  // Interrupt register
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      int_r <= 1'b0;
    else if (clk_en)
      int_r <= data_rdy && pass && !halt_out;
  end

  // ************************************
  // Parallel read path
  // ************************************
  // Read mux
  always @* begin
    case (adr_s1)
      `FMSC_A_DATA:  rd_mux = corr_data;
      `FMSC_A_BIC:   rd_mux = status_in;
      `FMSC_A_BLOCK_SYNC_PROTECTION: rd_mux = block_no_in;
      default:       rd_mux = 8'h00;
    endcase
  end

  // Read data register
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      par_dout <= 8'h00;
    else if (clk_en)
      par_dout <= rd_mux;
  end

  assign par_doe = !ser_mode && cs_s[1] && rd_s[1];

  // ************************************
  // Serial engine
  // ************************************
  // Serial read mux
  always @* begin
    case (sh_nxt)
      `FMSC_S_DATA: srd_mux = corr_data;
      `FMSC_S_STAT: srd_mux = status_in;
      `FMSC_S_OUTPUT_BLOCK_NUMBER: srd_mux = block_no_in;
      default:      srd_mux = 8'h00;
    endcase
  end

  // Shift in address then data, LSB first
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sh_r     <= 8'h00;
      bit_r    <= 4'h0;
      adr_ok_r <= 1'b0;
      sadr_r   <= 8'h00;
      tx_r     <= 8'h00;
      tx_on_r  <= 1'b0;
    end else if (clk_en) begin
      if (!ce_s[1] || !ser_mode) begin
        bit_r    <= 4'h0;
        adr_ok_r <= 1'b0;
        tx_on_r  <= 1'b0;
      end else if (sck_rise) begin
        sh_r <= sh_nxt;
        if (bit_r == `FMSC_BITS - 4'h1) begin
          bit_r <= 4'h0;
          if (!adr_ok_r) begin
            adr_ok_r <= 1'b1;
            sadr_r   <= sh_nxt;
            tx_r     <= srd_mux;
            tx_on_r  <= (srd_mux != 8'h00) || (sh_nxt == `FMSC_S_DATA)
                        || (sh_nxt == `FMSC_S_STAT) || (sh_nxt == `FMSC_S_OUTPUT_BLOCK_NUMBER);
          end else if (tx_on_r)
            tx_r <= (sadr_r == `FMSC_S_DATA) ? corr_data : tx_r;
        end else
          bit_r <= bit_r + 4'h1;
      end else if (sck_fall && tx_on_r && (bit_r != 4'h0)) begin
        tx_r <= {1'b0, tx_r[7:1]};
      end
    end
  end

  // ************************************
  // Serial data output
  // ************************************
  // Undriven during sync reset
  assign ser_do_oe = ser_mode && !sync_reset
                     && (tx_on_r || control_one[`FMSC_B_DOINT]);
  assign ser_do    = tx_on_r ? tx_r[0] : !int_r;
endmodule

// File: fmsc_host.sv
`timescale 1ns/100ps
// ****
// Host on the parallel and serial ports
// ****
module fmsc_host (
  input  wire       sys_clk,
  input  wire [7:0] par_dout,
  input  wire       par_doe,
  input  wire       ser_do,
  output reg        par_cs_n,
  output reg        par_wr_n,
  output reg        par_rd_n,
  output reg  [3:0] par_addr,
  output reg  [7:0] par_din,
  output reg        ser_ce,
  output reg        ser_clk,
  output reg        ser_di
);
  // Idle lines; serial clock stands low outside frames
  initial begin
    {par_cs_n, par_wr_n, par_rd_n} = 3'h7;
    par_addr = 4'hF;
    par_din = 8'hFF;
    {ser_ce, ser_clk, ser_di} = 3'h0;
  end
  // Wait falling edges
  task nf(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Write; strobes stay put well past the synchroniser
  task pw(input [3:0] a, input [7:0] d);
    begin
      @(negedge sys_clk);
      par_addr = a;
      par_din = d;
      {par_cs_n, par_wr_n} = 2'h0;
      nf(4);
      par_wr_n = 1'b1;
      nf(5);
      par_cs_n = 1'b1;
      nf(4);
      // Released lines no longer show the last value
      par_addr = ~a;
      par_din = ~d;
    end
  endtask
  // Read; data taken while select and strobe still low
  task pr(input [3:0] a, output [7:0] d, output e);
    begin
      @(negedge sys_clk);
      par_addr = a;
      {par_cs_n, par_rd_n} = 2'h0;
      nf(5);
      d = par_dout;
      e = par_doe;
      {par_cs_n, par_rd_n} = 2'h3;
      nf(4);
    end
  endtask
  // Frame of address and data bytes, LSB first; q takes the output bits
  task sx(input [7:0] a, input [7:0] d, output [7:0] q);
    integer i;
    begin
      @(negedge sys_clk);
      ser_ce = 1'b1;
      nf(4);
      for (i = 0; i < 16; i = i + 1) begin
        ser_clk = 1'b0;
        ser_di = i < 8 ? a[i] : d[i - 8];
        nf(4);
        // Output bit settles after the fall, taken before the rise
        q[i % 8] = ser_do;
        ser_clk = 1'b1;
        nf(4);
      end
      ser_clk = 1'b0;
      nf(4);
      ser_ce = 1'b0;
      ser_di = ~ser_di;
      nf(4);
    end
  endtask
endmodule

// File: fmsc_regs.vh
// Behaviour
// - Interface select pin picks parallel or serial
// - Reset loads documented write register values
// - Writes to address 00H are ignored
// - BIC_ERROR_ALLOWANCE matches when errors within allowance
// - Upper allowance unsynced, lower allowance synced
// - Unsynced: count matches, clear on mismatch
// - Synced: count misses, clear on match
// - Programmed protection value is count minus one
// - Block protection resets to 17H
// - Frame sync protection by inflection points
// - Bit 2 halts vertical correction
// - Bit 3 stops correction and output
// - Bit 4 forces sync circuits unsynchronized
// - Sync reset suppresses interrupt and output
// - Bit 5 clear outputs only good data
// - Bit 6 makes serial output show interrupt, active low
// - Bit 7 resets group check circuit
`ifndef FMSC_REGS_VH
`define FMSC_REGS_VH
// ************************************
// Addresses
// ************************************
`define FMSC_A_DATA    4'h0
`define FMSC_A_BIC     4'h1
`define FMSC_A_BLOCK_SYNC_PROTECTION   4'h2
`define FMSC_A_FRAME_SYNC_PROTECTION   4'h3
`define FMSC_A_CONTROL_ONE    4'h4
`define FMSC_A_CONTROL_TWO    4'h5
`define FMSC_A_CRC     4'h6
`define FMSC_S_DATA    8'hFB
`define FMSC_S_STAT    8'hF1
`define FMSC_S_OUTPUT_BLOCK_NUMBER    8'hF2
// ************************************
// Reset values
// ************************************
`define FMSC_RST_BIC   8'h22
`define FMSC_RST_PROT  8'h17
`define FMSC_RST_CTL   8'h00
// ************************************
// Control one bit positions
// ************************************
`define FMSC_B_VHALT   2
`define FMSC_B_ECSTOP  3
`define FMSC_B_SYNCRST 4
`define FMSC_B_INTALL  5
`define FMSC_B_DOINT   6
`define FMSC_B_CRCRST  7
// ************************************
// Serial frame
// ************************************
`define FMSC_BITS      4'h8
`endif

// File: fmsc_sva.sv
`timescale 1ns/100ps
// ****
// Port checks of the register bank
// ****
module fmsc_sva (
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  input wire par_cs_n,
  input wire par_doe,
  input wire ser_do_oe,
  input wire blk_tick,
  input wire blk_det,
  input wire frm_tick,
  input wire data_rdy,
  input wire data_good,
  input wire blk_sync,
  input wire frm_sync,
  input wire int_req,
  input wire correction_stop,
  input wire sync_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_doe_needs_cs: assert property (par_doe |-> !$past(par_cs_n, 2) || !$past(par_cs_n, 3))
    else $error("parallel drive without select");
  a_int_cause: assert property (int_req |-> $past(data_rdy) && !$past(sync_reset) && !$past(correction_stop))
    else $error("interrupt without allowed cause");
  a_int_good_pass: assert property (clk_en && data_rdy && data_good && blk_sync && frm_sync && !sync_reset
    && !correction_stop |=> int_req)
    else $error("good data raised no interrupt");
  a_rst_no_drive: assert property (sync_reset |-> !ser_do_oe)
    else $error("serial output driven in sync reset");
  a_rst_unsync: assert property (sync_reset |=> !blk_sync && !frm_sync)
    else $error("sync held through sync reset");
  a_blk_moment: assert property ($changed(blk_sync) |-> $past(blk_tick) || $past(sync_reset))
    else $error("block sync moved off timing");
  a_frm_moment: assert property ($changed(frm_sync) |-> $past(frm_tick) || $past(sync_reset))
    else $error("frame sync moved off timing");
  a_blk_gain_match: assert property ($rose(blk_sync) |-> $past(blk_det))
    else $error("block sync gained without code");
  c_blk_lock: cover property ($rose(blk_sync));
  c_int: cover property (int_req);
  c_do: cover property (ser_do_oe);
endmodule

bind fmsc_ctrl_regs fmsc_sva fmsc_sva_inst (.*);

// File: fmsc_tb.sv
`timescale 1ns/100ps
module testbench;
  // ****
  // Bench signals, named as the ports
  // ****
  reg        sys_clk = 1'b0;
  reg        resetn = 1'b0;
  reg        clk_en = 1'b1;
  reg        interface_select = 1'b0;
  reg        blk_tick = 1'b0, frm_tick = 1'b0, blk_det = 1'b0, data_rdy = 1'b0, data_good = 1'b0;
  reg  [4:0] blk_errs = 5'h00;
  reg  [7:0] corr_data = 8'hC6, status_in = 8'h5A, block_no_in = 8'h3B, q;
  reg        e;
  wire       frm_det = blk_det;
  wire [4:0] frm_errs = blk_errs;
  wire       par_cs_n, par_wr_n, par_rd_n, par_doe, ser_ce, ser_clk, ser_di, ser_do, ser_do_oe, group_crc_stb;
  wire [3:0] par_addr;
  wire [7:0] par_din, par_dout, control_two, group_crc_input;
  wire       blk_sync, frm_sync, int_req, vertical_pass_halt, correction_stop, sync_reset, group_check_reset;
  wire [7:0] syn = {6'h00, blk_sync, frm_sync};
  wire [7:0] ctl = {group_check_reset, 2'h0, sync_reset, correction_stop, vertical_pass_halt, 2'h0};
  wire [7:0] sdo = {6'h00, ser_do_oe, ser_do};
  integer    cyc = 0, n_mismatch = 0, n_compared = 0, i;
  always #5 sys_clk = ~sys_clk;
  fmsc_host fmsc_host_inst (.*);
  fmsc_ctrl_regs fmsc_ctrl_regs_inst (.*);
  // Compare and count
  task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // One timing tick for block and/or frame loop
  task stp(input b, input f, input d, input [4:0] x);
    begin
      @(negedge sys_clk);
      {blk_tick, frm_tick, blk_det} = {b, f, d};
      blk_errs = x;
      @(negedge sys_clk);
      {blk_tick, frm_tick, blk_det} = 3'h0;
    end
  endtask
  // Packet ready under a control setting
  task irq(input [7:0] c, input g, input x);
    begin
      fmsc_host_inst.pw(4'h4, c);
      @(negedge sys_clk);
      {data_rdy, data_good} = {1'b1, g};
      @(posedge sys_clk);
      #1;
      chk("int_req", {7'h00, int_req}, {7'h00, x});
      @(negedge sys_clk);
      data_rdy = 1'b0;
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (3) @(negedge sys_clk);
    // Default limits: a three-error code breaks the run of matches
    stp(1, 1, 1, 5'h02);
    stp(1, 1, 1, 5'h03);
    stp(1, 1, 1, 5'h02);
    chk("sync", syn, 8'h00);
    stp(1, 1, 1, 5'h02);
    chk("sync", syn, 8'h03);
    for (i = 0; i < 15; i = i + 1)
      stp(1, 1, i == 7, 5'h00);
    chk("sync", syn, 8'h03);
    stp(1, 1, 0, 5'h00);
    chk("sync", syn, 8'h00);
    fmsc_host_inst.pw(4'h1, 8'h02);
    fmsc_host_inst.pw(4'h2, 8'h20);
    for (i = 0; i < 5; i = i + 1)
      stp(1, 0, 1, {4'h0, i < 3});
    chk("sync", syn, 8'h00);
    stp(1, 0, 1, 5'h00);
    chk("sync", syn, 8'h02);
    stp(1, 0, 1, 5'h02);
    chk("sync", syn, 8'h02);
    stp(1, 0, 0, 5'h00);
    chk("sync", syn, 8'h00);
    // Sync reset holds loops unsynced
    stp(0, 1, 1, 5'h00);
    stp(0, 1, 1, 5'h00);
    chk("sync", syn, 8'h01);
    fmsc_host_inst.pw(4'h4, 8'h10);
    chk("sync", syn, 8'h00);
    chk("do", sdo & 8'h02, 8'h00);
    stp(0, 1, 1, 5'h00);
    stp(0, 1, 1, 5'h00);
    chk("sync", syn, 8'h00);
    fmsc_host_inst.pw(4'h4, 8'h00);
    for (i = 2; i < 8; i = i + 1) begin
      fmsc_host_inst.pw(4'h4, 8'h01 << i);
      chk("ctl", ctl, (8'h01 << i) & 8'h9C);
    end
    fmsc_host_inst.pw(4'h0, 8'h00);
    chk("ctl", ctl, 8'h80);
    fmsc_host_inst.pw(4'h4, 8'h00);
    fmsc_host_inst.pw(4'h5, 8'h3C);
    chk("control_two", control_two, 8'h3C);
    fmsc_host_inst.pw(4'h6, 8'hA7);
    chk("crc", group_crc_input, 8'hA7);
    // Block needs three matches, frame two, after sync reset cleared the counts
    stp(1, 1, 1, 5'h00);
    stp(1, 1, 1, 5'h00);
    chk("sync", syn, 8'h01);
    stp(1, 1, 1, 5'h00);
    chk("sync", syn, 8'h03);
    irq(8'h00, 1, 1);
    irq(8'h00, 0, 0);
    irq(8'h20, 0, 1);
    irq(8'h28, 1, 0);
    irq(8'h30, 0, 0);
    // Serial port active, parallel ignored
    interface_select = 1'b1;
    repeat (4) @(negedge sys_clk);
    fmsc_host_inst.sx(8'h04, 8'h00, q);
    fmsc_host_inst.sx(8'h05, 8'hA5, q);
    chk("control_two", control_two, 8'hA5);
    fmsc_host_inst.pw(4'h5, 8'h3C);
    chk("control_two", control_two, 8'hA5);
    fmsc_host_inst.sx(8'hFB, 8'h55, q);
    chk("data", q, 8'hC6);
    fmsc_host_inst.sx(8'h04, 8'h40, q);
    chk("do", sdo, 8'h03);
    fmsc_host_inst.sx(8'h04, 8'h50, q);
    chk("do", sdo & 8'h02, 8'h00);
    fmsc_host_inst.sx(8'h04, 8'h00, q);
    interface_select = 1'b0;
    repeat (4) @(negedge sys_clk);
    fmsc_host_inst.pr(4'h0, q, e);
    chk("data", q, 8'hC6);
    chk("doe", {7'h00, e}, 8'h01);
    fmsc_host_inst.pr(4'h1, q, e);
    chk("stat", q, 8'h5A);
    fmsc_host_inst.pr(4'h2, q, e);
    chk("output_block_number", q, 8'h3B);
    wrap_up;
  end
endmodule
